// >>> hw/dacs_pkg.sv
package dacs_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0] MON_SETUP_ADDR = 5'h11; // Setup register address
    localparam int REG_W = 22; // Register width
    localparam logic [21:0] MON_SETUP_RESET = 22'h110000; // Reset value
    localparam int FAULT_BIT = 21; // Fault pin status position
    localparam int ADDR_HI = 20; // Address field top
    localparam int ADDR_LO = 16; // Address field bottom
    localparam int CMD_HI = 10; // Sequence command top
    localparam int CMD_LO = 8; // Sequence command bottom
    localparam int DATA_HI = 7; // Sequence data top
    localparam int DATA_LO = 5; // Sequence data bottom
    localparam int SEL_HI = 4; // Node select top
    localparam logic [2:0] CMD_RESET = 3'h0; // Command reset value
    localparam logic [2:0] DATA_RESET = 3'h0; // Sequence data reset value
    localparam logic [4:0] SEL_RESET = 5'h00; // Node select reset value
    localparam logic [2:0] CMD_SINGLE = 3'h4; // Single conversion command

    // ----------------------------------------------------------------
    // Node select codes
    // ----------------------------------------------------------------
    localparam logic [4:0] NODE_DIE_TEMP = 5'h00;
    localparam logic [4:0] NODE_EXT_REF = 5'h03;
    localparam logic [4:0] NODE_SEC_REF = 5'h04;
    localparam logic [4:0] NODE_SENSE_POS = 5'h0D;
    localparam logic [4:0] NODE_SENSE_NEG = 5'h0E;
    localparam logic [4:0] NODE_INT_SUPPLY = 5'h14;
    localparam logic [4:0] NODE_REGULATOR = 5'h15;
    localparam logic [4:0] NODE_LOGIC_SUPPLY = 5'h16;
    localparam logic [4:0] NODE_REF_GND = 5'h18;
    localparam logic [4:0] NODE_ANALOG_GND = 5'h19;
    localparam logic [4:0] NODE_DIGITAL_GND = 5'h1A;
    localparam logic [4:0] NODE_SUPPLY1 = 5'h1B;
    localparam logic [4:0] NODE_SUPPLY2 = 5'h1C;
    localparam logic [4:0] NODE_NEG_SUPPLY = 5'h1D;
    localparam logic [4:0] NODE_REF_OUT = 5'h1F;

    // Register write request from the serial interface logic
    typedef struct packed {
        logic valid; // One-cycle write strobe
        logic [4:0] addr; // Register address
        logic [21:0] data; // Write data
    } dacs_wr_type;

    // Converter mux command
    typedef struct packed {
        logic start; // One-cycle conversion start
        logic node_valid; // Node is routed (not reserved)
        logic [4:0] node; // Node select code
    } dacs_conv_type;
endpackage

// >>> hw/dacs_node_decode.sv
`timescale 1ns/1ns
// Decodes a node select code into a one-hot mux line and a valid flag
module dacs_node_decode (
    input wire logic [4:0] i_code,
    input wire logic i_ext_ref_buf_en,
    output logic [31:0] o_onehot,
    output logic o_valid
);
    // ----------------------------------------------------------------
    // Node validity
    // ----------------------------------------------------------------
    function automatic logic node_known(input logic [4:0] c);
        case (c)
            dacs_pkg::NODE_DIE_TEMP, dacs_pkg::NODE_SENSE_POS, dacs_pkg::NODE_SENSE_NEG: node_known = 1'b1;
            dacs_pkg::NODE_SEC_REF: node_known = 1'b1;
            dacs_pkg::NODE_INT_SUPPLY, dacs_pkg::NODE_REGULATOR, dacs_pkg::NODE_LOGIC_SUPPLY,
            dacs_pkg::NODE_REF_GND, dacs_pkg::NODE_ANALOG_GND, dacs_pkg::NODE_DIGITAL_GND,
            dacs_pkg::NODE_SUPPLY1, dacs_pkg::NODE_SUPPLY2, dacs_pkg::NODE_NEG_SUPPLY,
            dacs_pkg::NODE_REF_OUT: node_known = 1'b1;
            default: node_known = 1'b0;
        endcase
    endfunction

    // Route only known nodes; external reference needs its buffer powered
    always_comb begin
        o_valid = node_known(i_code);
        if (i_code == dacs_pkg::NODE_EXT_REF) begin
            o_valid = i_ext_ref_buf_en;
        end
        o_onehot = 32'h0000_0000;
        if (o_valid) begin
            o_onehot[i_code] = 1'b1;
        end
    end
endmodule // dacs_node_decode

// >>> hw/dacs_setup.sv
`timescale 1ns/1ns
module dacs_setup (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire dacs_pkg::dacs_wr_type I_WR,
    input wire logic [4:0] I_RD_ADDR,
    input wire logic I_FAULT_PIN,
    input wire logic I_EXT_REF_BUF_EN,
    output logic [21:0] O_RD_DATA,
    output logic O_RD_HIT,
    output dacs_pkg::dacs_conv_type O_CONV,
    output logic [31:0] O_MUX_ONEHOT,
    output logic [1:0] O_MODE
);
    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_KEY_SEQ,
        MODE_AUTO_SEQ,
        MODE_SINGLE_NOW,
        MODE_SINGLE_KEY
    } dacs_mode_type;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [2:0] cmd_reg; // Sequence command field
    logic [2:0] cmd_next;
    logic [2:0] seq_data_reg; // Sequence data field
    logic [2:0] seq_data_next;
    logic [4:0] sel_reg; // Node select field
    logic [4:0] sel_next;
    logic start_reg; // Conversion start pulse
    logic start_next;
    dacs_mode_type mode_reg; // Current converter mode
    dacs_mode_type mode_next;
    logic fault_meta_reg; // Fault pin sync stage 1
    logic fault_sync_reg; // Fault pin sync stage 2
    logic wr_hit; // Write to this register
    logic [31:0] onehot; // Decoded mux line
    logic node_ok; // Node is routed

    assign wr_hit = I_WR.valid && (I_WR.addr == dacs_pkg::MON_SETUP_ADDR);

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    // Only writable fields take write data; bits 21:11 are dropped
    always_comb begin
        cmd_next = cmd_reg;
        seq_data_next = seq_data_reg;
        sel_next = sel_reg;
        start_next = 1'b0;
        mode_next = mode_reg;
        if (wr_hit) begin
            cmd_next = I_WR.data[dacs_pkg::CMD_HI:dacs_pkg::CMD_LO];
            seq_data_next = I_WR.data[dacs_pkg::DATA_HI:dacs_pkg::DATA_LO];
            sel_next = I_WR.data[dacs_pkg::SEL_HI:0];
            // Every write carrying the single command starts one conversion
            if (I_WR.data[dacs_pkg::CMD_HI:dacs_pkg::CMD_LO] == dacs_pkg::CMD_SINGLE) begin
                start_next = 1'b1;
                mode_next = MODE_SINGLE_NOW;
            end else begin
                // Reserved codes start nothing and leave the mode as it was
                mode_next = mode_reg;
            end
        end
    end

    // Registers
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cmd_reg <= dacs_pkg::CMD_RESET;
            seq_data_reg <= dacs_pkg::DATA_RESET;
            sel_reg <= dacs_pkg::SEL_RESET;
            start_reg <= 1'b0;
            mode_reg <= MODE_KEY_SEQ;
        end else begin
            cmd_reg <= cmd_next;
            seq_data_reg <= seq_data_next;
            sel_reg <= sel_next;
            start_reg <= start_next;
            mode_reg <= mode_next;
        end
    end

    // ----------------------------------------------------------------
    // Fault pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fault_meta_reg <= 1'b0;
            fault_sync_reg <= 1'b0;
        end else begin
            fault_meta_reg <= I_FAULT_PIN;
            fault_sync_reg <= fault_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Node decode
    // ----------------------------------------------------------------
    dacs_node_decode u_decode (
        .i_code(sel_reg),
        .i_ext_ref_buf_en(I_EXT_REF_BUF_EN),
        .o_onehot(onehot),
        .o_valid(node_ok)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Readback: status bit, own address, zeros in reserved bits
    always_comb begin
        O_RD_HIT = (I_RD_ADDR == dacs_pkg::MON_SETUP_ADDR);
        O_RD_DATA = 22'h000000;
        if (O_RD_HIT) begin
            O_RD_DATA[dacs_pkg::FAULT_BIT] = fault_sync_reg;
            O_RD_DATA[dacs_pkg::ADDR_HI:dacs_pkg::ADDR_LO] = dacs_pkg::MON_SETUP_ADDR;
            O_RD_DATA[dacs_pkg::CMD_HI:dacs_pkg::CMD_LO] = cmd_reg;
            O_RD_DATA[dacs_pkg::DATA_HI:dacs_pkg::DATA_LO] = seq_data_reg;
            O_RD_DATA[dacs_pkg::SEL_HI:0] = sel_reg;
        end
    end

    assign O_CONV.start = start_reg;
    assign O_CONV.node_valid = node_ok;
    assign O_CONV.node = sel_reg;
    assign O_MUX_ONEHOT = onehot;
    assign O_MODE = mode_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_cmd_write;
        wr_hit && (I_WR.data[10:8] == 3'h4);
    endsequence

    property p_start_one;
        @(posedge I_CLK) disable iff (!I_RST_N) s_cmd_write |=> start_reg ##1 (!start_reg || $past(wr_hit));
    endproperty
    a_start_one: assert property (p_start_one) else $error("start not one pulse per write");

    property p_no_spurious;
        @(posedge I_CLK) disable iff (!I_RST_N) start_reg |-> $past(wr_hit) && $past(I_WR.data[10:8]) == 3'h4;
    endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("start without command");

    property p_rd_addr;
        @(posedge I_CLK) disable iff (!I_RST_N) O_RD_HIT |-> O_RD_DATA[20:16] == 5'h11 && O_RD_DATA[15:11] == 5'h00;
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("address field wrong");

    // Only once the synchroniser has run two edges out of reset
    property p_fault;
        @(posedge I_CLK) disable iff (!I_RST_N)
            (O_RD_HIT && $past(I_RST_N) && $past(I_RST_N, 2)) |-> O_RD_DATA[21] == $past(I_FAULT_PIN, 2);
    endproperty
    a_fault: assert property (p_fault) else $error("fault bit wrong");

    property p_sel_store;
        @(posedge I_CLK) disable iff (!I_RST_N) wr_hit |=> sel_reg == $past(I_WR.data[4:0]);
    endproperty
    a_sel_store: assert property (p_sel_store) else $error("node select not stored");

    property p_ext_ref;
        @(posedge I_CLK) disable iff (!I_RST_N) (sel_reg == 5'h03) |-> node_ok == I_EXT_REF_BUF_EN;
    endproperty
    a_ext_ref: assert property (p_ext_ref) else $error("external reference gating wrong");

    property p_reserved_zero;
        @(posedge I_CLK) disable iff (!I_RST_N) (sel_reg == 5'h01 || sel_reg == 5'h1E) |-> !node_ok && O_MUX_ONEHOT == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved node routed");

    property p_known_nodes;
        @(posedge I_CLK) disable iff (!I_RST_N)
            (sel_reg inside {5'h00, 5'h04, 5'h0D, 5'h0E, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C,
                5'h1D, 5'h1F}) |-> node_ok && O_MUX_ONEHOT[sel_reg];
    endproperty
    a_known_nodes: assert property (p_known_nodes) else $error("listed node not routed");

    property p_mode;
        @(posedge I_CLK) disable iff (!I_RST_N) start_reg |-> mode_reg == MODE_SINGLE_NOW;
    endproperty
    a_mode: assert property (p_mode) else $error("mode not single");

    property p_reset_val;
        @(posedge I_CLK) $rose(I_RST_N) |-> cmd_reg == 3'h0 && sel_reg == 5'h00 && seq_data_reg == 3'h0;
    endproperty
    a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

    // Writes to other registers leave this one untouched and start nothing
    property p_other_addr;
        @(posedge I_CLK) disable iff (!I_RST_N)
            (I_WR.valid && I_WR.addr != 5'h11) |=> !start_reg && $stable(sel_reg) && $stable(cmd_reg);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("write to another address took effect");

    // Command and sequence data fields keep what was written
    property p_field_store;
        @(posedge I_CLK) disable iff (!I_RST_N)
            wr_hit |=> cmd_reg == $past(I_WR.data[10:8]) && seq_data_reg == $past(I_WR.data[7:5]);
    endproperty
    a_field_store: assert property (p_field_store) else $error("command or sequence data not stored");

    // Mux line is one-hot on a routed node and all zero otherwise
    property p_onehot;
        @(posedge I_CLK) disable iff (!I_RST_N)
            O_MUX_ONEHOT == (node_ok ? (32'h0000_0001 << sel_reg) : 32'h0000_0000);
    endproperty
    a_onehot: assert property (p_onehot) else $error("mux line not one-hot on node");
endmodule // dacs_setup

// >>> test/dacs_host_model.sv
`timescale 1ns/1ns
// Host side of the register port; every change lands on a falling edge
module dacs_host_model (
    input wire logic i_clk,
    input wire logic [21:0] i_rd_data,
    output dacs_pkg::dacs_wr_type o_wr,
    output logic [4:0] o_rd_addr,
    output logic o_fault_pin,
    output logic o_ext_ref_buf_en
);
    // Idle port at time zero
    initial begin
        o_wr = '0;
        o_rd_addr = 5'h00;
        o_fault_pin = 1'b0;
        o_ext_ref_buf_en = 1'b0;
    end
    // Write held over one rising edge; strobe stays up so writes can follow back to back
    task automatic wr(input logic [4:0] addr, input logic [21:0] data);
        o_wr.valid = 1'b1;
        o_wr.addr = addr;
        o_wr.data = data;
        @(negedge i_clk);
    endtask
    // Single conversion; only the legal command, sequence data left at zero
    task automatic conv(input logic [4:0] node);
        wr(dacs_pkg::MON_SETUP_ADDR, {11'h000, dacs_pkg::CMD_SINGLE, dacs_pkg::DATA_RESET, node});
    endtask
    // Drop the strobe; stale data is scrambled so nothing leans on it
    task automatic idle();
        o_wr.valid = 1'b0;
        o_wr.data = ~o_wr.data;
    endtask
    // Fault pin level and reference buffer enable
    task automatic pins(input logic fault, input logic buf_en);
        o_fault_pin = fault;
        o_ext_ref_buf_en = buf_en;
    endtask
    // Combinational readback, sampled once settled; returns on the next falling edge
    task automatic rd(input logic [4:0] addr, output logic [21:0] data);
        o_rd_addr = addr;
        #1;
        data = i_rd_data;
        @(negedge i_clk);
    endtask
endmodule // dacs_host_model

// >>> test/dacs_setup_tb_top.sv
`timescale 1ns/1ns
module dacs_setup_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dacs_pkg::dacs_wr_type wr;
    dacs_pkg::dacs_conv_type conv;
    logic [4:0] rd_addr;
    logic fault_pin;
    logic buf_en;
    logic [21:0] rd_data;
    logic rd_hit;
    logic [31:0] onehot;
    logic [1:0] mode;
    logic [21:0] rv;
    int err_total = 0;
    int cmp_count = 0;
    // 250 MHz clock
    always #2 clk = ~clk;
    dacs_host_model host (.i_clk(clk), .i_rd_data(rd_data), .o_wr(wr), .o_rd_addr(rd_addr),
        .o_fault_pin(fault_pin), .o_ext_ref_buf_en(buf_en));
    dacs_setup dut (.I_CLK(clk), .I_RST_N(rst_n), .I_WR(wr), .I_RD_ADDR(rd_addr), .I_FAULT_PIN(fault_pin),
        .I_EXT_REF_BUF_EN(buf_en), .O_RD_DATA(rd_data), .O_RD_HIT(rd_hit), .O_CONV(conv),
        .O_MUX_ONEHOT(onehot), .O_MODE(mode));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Which codes reach the converter
    function automatic logic node_ok(input logic [4:0] c, input logic en);
        case (c)
            5'h00, 5'h04, 5'h0D, 5'h0E, 5'h14, 5'h15, 5'h16, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D,
            5'h1F: node_ok = 1'b1;
            5'h03: node_ok = en;
            default: node_ok = 1'b0;
        endcase
    endfunction
    // Outputs in the cycle after a single-conversion write
    task automatic chk_conv(input logic [4:0] c, input logic en);
        chk("start", {31'h0, conv.start}, 32'h1);
        chk("node", {27'h0, conv.node}, {27'h0, c});
        chk("node_valid", {31'h0, conv.node_valid}, {31'h0, node_ok(c, en)});
        chk("onehot", onehot, node_ok(c, en) ? (32'h1 << c) : 32'h0);
    endtask
    // Bounded run
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        complete_run();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (7) @(negedge clk);
        host.rd(5'h11, rv);
        chk("reset_value", {10'h0, rv}, 32'h110000);
        chk("mode_reset", {30'h0, mode}, 32'h0);
        rst_n = 1'b1;
        $display("Test reset done");
        host.conv(dacs_pkg::NODE_SEC_REF);
        chk_conv(5'h04, 1'b0);
        chk("mode_single", {30'h0, mode}, 32'h2);
        host.idle();
        @(negedge clk);
        chk("start_once", {31'h0, conv.start}, 32'h0);
        host.conv(5'h0D);
        chk_conv(5'h0D, 1'b0);
        host.conv(5'h0D);
        chk_conv(5'h0D, 1'b0);
        $display("Test single conversion done");
        for (int i = 0; i < 32; i++) begin
            host.conv(i[4:0]);
            chk_conv(i[4:0], 1'b0);
        end
        host.pins(1'b0, 1'b1);
        host.conv(dacs_pkg::NODE_EXT_REF);
        chk_conv(5'h03, 1'b1);
        $display("Test node sweep done");
        host.wr(5'h11, 22'h3FFC1F);
        host.idle();
        host.rd(5'h11, rv);
        chk("ro_fields", {10'h0, rv}, 32'h11041F);
        host.wr(5'h12, 22'h000404);
        host.idle();
        chk("other_addr_start", {31'h0, conv.start}, 32'h0);
        host.rd(5'h12, rv);
        chk("other_addr_hit", {31'h0, rd_hit}, 32'h0);
        chk("other_addr_data", {10'h0, rv}, 32'h0);
        host.rd(5'h11, rv);
        chk("other_addr_keep", {10'h0, rv}, 32'h11041F);
        chk("own_addr_hit", {31'h0, rd_hit}, 32'h1);
        $display("Test field access done");
        host.pins(1'b1, 1'b1);
        repeat (3) @(negedge clk);
        host.rd(5'h11, rv);
        chk("fault_high", {10'h0, rv}, 32'h31041F);
        host.pins(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        rst_n = 1'b0;
        host.rd(5'h11, rv);
        chk("rereset_value", {10'h0, rv}, 32'h110000);
        chk("rereset_mode", {30'h0, mode}, 32'h0);
        @(negedge clk);
        rst_n = 1'b1;
        host.conv(dacs_pkg::NODE_REF_OUT);
        chk_conv(5'h1F, 1'b1);
        host.idle();
        @(negedge clk);
        chk("rereset_start_once", {31'h0, conv.start}, 32'h0);
        $display("Test fault and reset done");
        complete_run();
    end
endmodule // dacs_setup_tb_top
